// ---- serial_port_defines.vh ----
// register offsets, field positions, reset values and timing counts of the serial port
// assumes the includer places the apb slave at any aligned base
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_SERIAL_CONTROL 12'h000
`define OFS_DATA 12'h004
`define OFS_POWER_CONTROL 12'h008
`define OFS_BAUD_CONTROL 12'h00C
`define OFS_BAUD_RELOAD 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018
// ****************************************
// serial control bit positions
// ****************************************
`define BIT_FE_OR_MODE_LOW 7
`define BIT_MODE_HIGH 6
`define BIT_MP_ENABLE 5
`define BIT_RX_ENABLE 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0
// power control: doubler bit 7, error select bit 6
`define BIT_BAUD_DOUBLER 7
`define BIT_ERROR_SELECT 6
// baud control: run bit 4, shift clock select bit 0
`define BIT_BRG_RUN 4
`define BIT_SHIFT_CLOCK_SELECT 0
`define SERIAL_CONTROL_RESET 8'h00
// ****************************************
// timing divisors in peripheral clocks
// ****************************************
`define DIV_MODE0 6
`define DIV_MODE2 32
`define DIV_MODE2_DOUBLED 16
`define OVERSAMPLE 16
`endif

// ---- serial_port_control.v ----
// serial port control: mode select, 8051-style uart tx/rx, flags, apb registers, irq
// assumes ref_clk is the peripheral clock and rxd_pin is asynchronous to it
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"

// Operation
// - an invalid stop bit on a received frame sets the framing error flag in bit 7; here only while error select is 1.
// - the framing error flag stays set until software writes zero or reset.
// - bit 7 accesses reach the error flag when error select is 1, else mode low bit.
// - the two mode bits, mode low bit (bit 7) first, pick mode 0, 1, 2 or 3.
// - mode 0 shifts at clock/6, mode 2 at clock/32 or /16, modes 1 and 3 by generator.
// - multiprocessor enable filters frames in modes 2, 3 and 1; software keeps it off in 0.
// - frames are accepted only while receive enable is 1.
// - in modes 2 and 3 the transmit ninth bit is sent as the ninth data bit.
// - rx ninth bit takes bit 9 in modes 2/3, the stop bit in mode 1 without multiprocessor.
// - tx done sets after bit 8 in mode 0 and at stop bit start in modes 1 to 3.
// - rx done sets after bit 8 in mode 0 and holds until software writes zero.
// - the internal generator clocks modes 1 and 3, and mode 0 when shift select is set.
// - the serial control register resets to zero and allows single bit set and clear.
// - with error detection on, rx done rises at the stop bit, not after the last data bit.
// - the baud doubler doubles the rate in modes 1, 2 and 3.
module serial_port_control (
  input wire ref_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire rxd_pin,
  output reg txd_out,
  output reg shift_clk_out,
  output reg shift_clk_oe,
  output reg rxd_out,
  output reg rxd_oe,
  output wire irq
);
  // ****************************************
  // registers
  // ****************************************
  reg mode_low_q, mode_high_q, multiprocessor_enable_q, rx_enable_q;
  reg tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q, framing_error_flag_q;
  reg baud_doubler_q, error_bit_select_q, brg_run_q, shift_clock_select_q;
  reg [7:0] baud_reload_q, rx_data_q, irq_status_q, irq_mask_q;
  // bit 7 (mode low) is the upper bit of the mode number, bit 6 the lower
  wire [1:0] mode = {mode_low_q, mode_high_q};
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire unmapped = (paddr > `OFS_IRQ_MASK) | (paddr[1:0] != 2'b00);
  // reads take one wait state so prdata already stands when pready is high;
  // writes complete with no wait
  reg rd_done_q;
  always @(posedge ref_clk) begin
    if (srst) rd_done_q <= 1'b0;
    else rd_done_q <= rd & ~rd_done_q;
  end
  assign pready = ~rd | rd_done_q;
  assign pslverr = psel & penable & unmapped;
  wire wr_ctrl = wr & (paddr == `OFS_SERIAL_CONTROL);
  wire wr_data = wr & (paddr == `OFS_DATA);

  // rx pin synchroniser; stage one feeds stage two only
  reg rxd_s1_q, rxd_s2_q;
  always @(posedge ref_clk) begin
    if (srst) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd_pin;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // ****************************************
  // bit clock generation
  // ****************************************
  // internal generator: tick every 2*(256-reload)/2^doubler clocks, then /16 oversample
  reg [8:0] brg_cnt_q;
  // span is 256 - reload; a reload of zero gives an undoubled period of 512, whose low nine bits wrap to
  // zero, so the reload below lands on 511 as wanted
  wire [9:0] brg_span = {2'b00, 8'hFF - baud_reload_q} + 10'h001;
  wire [9:0] brg_period = baud_doubler_q ? brg_span : {brg_span[8:0], 1'b0};
  wire brg_tick = brg_run_q & (brg_cnt_q == 9'h000);
  always @(posedge ref_clk) begin
    if (srst | ~brg_run_q) brg_cnt_q <= 9'h000;
    else if (brg_cnt_q == 9'h000) brg_cnt_q <= brg_period[8:0] - 9'h001;
    else brg_cnt_q <= brg_cnt_q - 9'h001;
  end
  // fixed divider for mode 0 (/6) and mode 2 (/32 or /16 as 16x oversample ticks)
  reg [4:0] fix_cnt_q;
  // mode 0 ticks every 3 clocks and toggles the shift clock per tick: one bit per 6
  wire [4:0] fix_top = (mode == 2'b00) ? 5'd2 : (baud_doubler_q ? 5'd0 : 5'd1);
  wire fix_tick = (fix_cnt_q == 5'd0);
  always @(posedge ref_clk) begin
    if (srst) fix_cnt_q <= 5'd0;
    else if (fix_tick) fix_cnt_q <= fix_top;
    else fix_cnt_q <= fix_cnt_q - 5'd1;
  end
  // oversample tick per mode: generator for 1 and 3, and for 0 when shift select set
  wire os_tick = (mode == 2'b10) ? fix_tick :
    (mode == 2'b00) ? (shift_clock_select_q ? brg_tick : fix_tick) : brg_tick;

  // ****************************************
  // transmitter
  // ****************************************
  reg [3:0] tx_os_q, tx_bit_q;
  reg [9:0] tx_shift_q;
  reg tx_busy_q, tx_done_set;
  wire [3:0] tx_last = (mode[1]) ? 4'd10 : ((mode == 2'b01) ? 4'd9 : 4'd7);
  always @(posedge ref_clk) begin
    tx_done_set <= 1'b0;
    if (srst) begin
      tx_busy_q <= 1'b0;
      tx_os_q <= 4'd0;
      tx_bit_q <= 4'd0;
      tx_shift_q <= 10'h3FF;
      txd_out <= 1'b1;
      shift_clk_out <= 1'b1;
    end else if (wr_data & ~tx_busy_q) begin
      tx_busy_q <= 1'b1;
      tx_os_q <= 4'd0;
      tx_bit_q <= 4'd0;
      // async: start low, data lsb first, ninth bit, stop high
      if (mode == 2'b00) tx_shift_q <= {2'b11, pwdata[7:0]};
      else tx_shift_q <= {tx_ninth_bit_q | ~mode[1], pwdata[7:0], 1'b0};
    end else if (tx_busy_q & os_tick) begin
      if (mode == 2'b00) begin
        // synchronous shift: data on rxd, clock on shift clock pin
        shift_clk_out <= ~shift_clk_out;
        if (~shift_clk_out) begin
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'd1;
          if (tx_bit_q == 4'd7) begin
            tx_busy_q <= 1'b0;
            tx_done_set <= 1'b1;
          end
        end
      end else begin
        tx_os_q <= tx_os_q + 4'd1;
        if (tx_os_q == 4'd0) begin
          txd_out <= (tx_bit_q == tx_last) ? 1'b1 : tx_shift_q[0];
          if (tx_bit_q == tx_last) tx_done_set <= 1'b1; // stop bit starts
          if (tx_bit_q != tx_last) tx_shift_q <= {1'b1, tx_shift_q[9:1]};
        end
        if (tx_os_q == 4'd15) begin
          tx_bit_q <= tx_bit_q + 4'd1;
          if (tx_bit_q == tx_last) tx_busy_q <= 1'b0;
        end
      end
    end
  end
  // mode 0 drives data on the rx line while shifting out
  always @(posedge ref_clk) begin
    if (srst) begin
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      shift_clk_oe <= 1'b0;
    end else begin
      rxd_out <= tx_shift_q[0];
      rxd_oe <= (mode == 2'b00) & tx_busy_q;
      shift_clk_oe <= (mode == 2'b00);
    end
  end

  // ****************************************
  // receiver (async modes); mode 0 receive shifts on the same clock
  // ****************************************
  reg [3:0] rx_os_q, rx_bit_q;
  reg [8:0] rx_shift_q;
  reg rx_busy_q, rxd_prev_q, rx_done_set, fe_set, rb8_load, rb8_val;
  wire [3:0] rx_stop = mode[1] ? 4'd10 : 4'd9;
  always @(posedge ref_clk) begin
    rx_done_set <= 1'b0;
    fe_set <= 1'b0;
    rb8_load <= 1'b0;
    rb8_val <= 1'b0;
    if (srst) begin
      rx_busy_q <= 1'b0;
      rx_os_q <= 4'd0;
      rx_bit_q <= 4'd0;
      rx_shift_q <= 9'h000;
      rxd_prev_q <= 1'b1;
      rx_data_q <= 8'h00;
    end else begin
      rxd_prev_q <= rxd_s2_q;
      if (~rx_enable_q) rx_busy_q <= 1'b0;
      else if (mode == 2'b00) begin
        // mode 0 receive: 8 bits clocked in when rx done is clear
        if (~rx_busy_q & ~rx_done_flag_q) begin
          rx_busy_q <= 1'b1;
          rx_bit_q <= 4'd0;
        end else if (rx_busy_q & os_tick & shift_clk_out) begin
          rx_shift_q <= {rxd_s2_q, rx_shift_q[8:1]};
          rx_bit_q <= rx_bit_q + 4'd1;
          if (rx_bit_q == 4'd7) begin
            rx_busy_q <= 1'b0;
            rx_data_q <= {rxd_s2_q, rx_shift_q[8:2]};
            rx_done_set <= 1'b1;
          end
        end
      end else if (~rx_busy_q) begin
        if (rxd_prev_q & ~rxd_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_os_q <= 4'd0;
          rx_bit_q <= 4'd0;
        end
      end else if (os_tick) begin
        rx_os_q <= rx_os_q + 4'd1;
        if (rx_os_q == 4'd7) begin
          // sample at mid bit
          rx_bit_q <= rx_bit_q + 4'd1;
          if (rx_bit_q == 4'd0 && rxd_s2_q) rx_busy_q <= 1'b0; // false start
          else if (rx_bit_q != 4'd0 && rx_bit_q != rx_stop) begin
            rx_shift_q <= {rxd_s2_q, rx_shift_q[8:1]};
            // with error detection off, done rises after the last data bit, except in mode 1 with multiprocessor enable set
            if (rx_bit_q == rx_stop - 4'd1 && ~error_bit_select_q) begin
              rx_data_q <= mode[1] ? rx_shift_q[8:1] : {rxd_s2_q, rx_shift_q[8:2]};
              if (~mode[1] | ~multiprocessor_enable_q | rxd_s2_q) begin
                rx_done_set <= ~mode[1] ? ~multiprocessor_enable_q : 1'b1;
                rb8_load <= mode[1];
                rb8_val <= rxd_s2_q;
              end
            end
          end else if (rx_bit_q == rx_stop) begin
            rx_busy_q <= 1'b0;
            if (~rxd_s2_q) fe_set <= error_bit_select_q;
            if (error_bit_select_q) begin
              rx_data_q <= mode[1] ? rx_shift_q[7:0] : rx_shift_q[8:1];
              if (mode[1] ? (~multiprocessor_enable_q | rx_shift_q[8]) :
                  (~multiprocessor_enable_q | rxd_s2_q)) begin
                rx_done_set <= 1'b1; // stop bit timing
                rb8_load <= 1'b1;
                rb8_val <= mode[1] ? rx_shift_q[8] : rxd_s2_q;
              end
            end else if (~mode[1] & ~multiprocessor_enable_q) begin
              rb8_load <= 1'b1;
              rb8_val <= rxd_s2_q; // stop bit in mode 1
            end else if (~mode[1] & multiprocessor_enable_q & rxd_s2_q) begin
              rx_done_set <= 1'b1; // mode 1 multiprocessor needs a valid stop
            end
          end
        end
      end
    end
  end

  // ****************************************
  // serial control and other registers
  // ****************************************
  // a write may set or clear any single bit; hardware sets win over clears
  always @(posedge ref_clk) begin
    if (srst) begin
      {mode_low_q, mode_high_q, multiprocessor_enable_q, rx_enable_q} <= 4'h0;
      {tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q} <= 4'h0;
      framing_error_flag_q <= 1'b0;
      baud_doubler_q <= 1'b0;
      error_bit_select_q <= 1'b0;
      brg_run_q <= 1'b0;
      shift_clock_select_q <= 1'b0;
      baud_reload_q <= 8'h00;
      irq_status_q <= 8'h00;
      irq_mask_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        if (error_bit_select_q) framing_error_flag_q <= pwdata[`BIT_FE_OR_MODE_LOW] | fe_set;
        else mode_low_q <= pwdata[`BIT_FE_OR_MODE_LOW];
        mode_high_q <= pwdata[`BIT_MODE_HIGH];
        multiprocessor_enable_q <= pwdata[`BIT_MP_ENABLE];
        rx_enable_q <= pwdata[`BIT_RX_ENABLE];
        tx_ninth_bit_q <= pwdata[`BIT_TX_NINTH];
      end
      // error flag survives good frames; only a zero write clears it
      if (fe_set) framing_error_flag_q <= 1'b1;
      if (rb8_load) rx_ninth_bit_q <= rb8_val;
      else if (wr_ctrl) rx_ninth_bit_q <= pwdata[`BIT_RX_NINTH];
      tx_done_flag_q <= tx_done_set | (wr_ctrl ? pwdata[`BIT_TX_DONE] : tx_done_flag_q);
      rx_done_flag_q <= rx_done_set | (wr_ctrl ? pwdata[`BIT_RX_DONE] : rx_done_flag_q);
      if (wr & (paddr == `OFS_POWER_CONTROL)) begin
        baud_doubler_q <= pwdata[`BIT_BAUD_DOUBLER];
        error_bit_select_q <= pwdata[`BIT_ERROR_SELECT];
      end
      if (wr & (paddr == `OFS_BAUD_CONTROL)) begin
        brg_run_q <= pwdata[`BIT_BRG_RUN];
        shift_clock_select_q <= pwdata[`BIT_SHIFT_CLOCK_SELECT];
      end
      if (wr & (paddr == `OFS_BAUD_RELOAD)) baud_reload_q <= pwdata[7:0];
      // sticky events: bit0 rx done, bit1 tx done, bit2 framing error; write one clears
      irq_status_q <= {5'h00, fe_set, tx_done_set, rx_done_set} |
        (irq_status_q & ~((wr & (paddr == `OFS_IRQ_STATUS)) ? pwdata[7:0] : 8'h00));
      if (wr & (paddr == `OFS_IRQ_MASK)) irq_mask_q <= pwdata[7:0];
    end
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // read mux, registered so data comes from flip-flops
  always @(posedge ref_clk) begin
    if (srst) prdata <= 32'h00000000;
    else if (rd & ~rd_done_q) begin
      case (paddr)
        `OFS_SERIAL_CONTROL: prdata <= {24'h000000,
          error_bit_select_q ? framing_error_flag_q : mode_low_q, mode_high_q,
          multiprocessor_enable_q, rx_enable_q, tx_ninth_bit_q, rx_ninth_bit_q,
          tx_done_flag_q, rx_done_flag_q};
        `OFS_DATA: prdata <= {24'h000000, rx_data_q};
        `OFS_POWER_CONTROL: prdata <= {24'h000000, baud_doubler_q, error_bit_select_q, 6'h00};
        `OFS_BAUD_CONTROL: prdata <= {27'h0000000, brg_run_q, 3'h0, shift_clock_select_q};
        `OFS_BAUD_RELOAD: prdata <= {24'h000000, baud_reload_q};
        `OFS_IRQ_STATUS: prdata <= {24'h000000, irq_status_q};
        `OFS_IRQ_MASK: prdata <= {24'h000000, irq_mask_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- serial_port_control_props.sv ----
// port checker for the serial port control block
// assumes one ref_clk domain and the sync active-high srst
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
module serial_port_control_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic txd_out,
  input wire logic shift_clk_oe,
  input wire logic rxd_oe,
  input wire logic irq
);
  // ****************************************
  // shared sequences
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // aligned offsets up to the mask register are mapped
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFS_IRQ_MASK);
  sequence acc_s; psel && penable; endsequence
  // an async bit lasts at least 16 clocks, so 8 low cycles is a safe floor
  sequence start_s; !txd_out [*8]; endsequence
  a_ready_write: assert property (acc_s ##0 pwrite |-> pready) else $error("write waited");
  a_read_ready: assert property (acc_s ##0 (!pwrite && !pready) |=> pready)
    else $error("read wait too long");
  a_slverr_map: assert property (acc_s |-> pslverr == !mapped) else $error("pslverr wrong");
  a_unmapped_zero: assert property (acc_s ##0 (!pwrite && !mapped) |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without read");
  a_reset_idle: assert property ($fell(srst) |-> txd_out && !shift_clk_oe && !rxd_oe)
    else $error("lines not idle after reset");
  a_reset_quiet: assert property ($fell(srst) |-> !irq && prdata == 32'h0)
    else $error("irq or prdata set after reset");
  a_start_bit: assert property ($fell(txd_out) && !shift_clk_oe |-> start_s)
    else $error("start bit too short");
  a_mask_quiet: assert property (acc_s ##0 (pwrite && paddr == `OFS_IRQ_MASK
    && pwdata[2:0] == 3'h0) |=> !irq) else $error("irq while fully masked");
endmodule
bind serial_port_control serial_port_control_props u_props (.ref_clk(ref_clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .txd_out(txd_out),
  .shift_clk_oe(shift_clk_oe), .rxd_oe(rxd_oe), .irq(irq));
`default_nettype wire

// ---- serial_remote.sv ----
// remote serial node: captures frames from txd and sends frames on rxd
// assumes a fixed bit time in ref_clk cycles and an idle-high line
`timescale 1ns/1ps
`default_nettype none
module serial_remote #(parameter int BIT_CLKS = 32) (
  input wire logic ref_clk,
  input wire logic txd_in,
  output var logic rxd_drive,
  output var logic got_stb,
  output var logic [10:0] got_frame
);
  logic [10:0] w;
  initial rxd_drive = 1'b1;
  // receiver samples mid bit; starts late so the pre-reset line is ignored
  initial begin
    got_stb = 1'b0;
    got_frame = 11'h000;
    repeat (20) @(posedge ref_clk);
    forever begin
      @(negedge txd_in);
      repeat (BIT_CLKS / 2) @(posedge ref_clk);
      for (int i = 0; i < 11; i++) begin
        w[i] = txd_in;
        repeat (BIT_CLKS) @(posedge ref_clk);
      end
      got_frame <= w;
      got_stb <= 1'b1;
      @(posedge ref_clk);
      got_stb <= 1'b0;
    end
  end
  // stop level is a choice so a bench can force a framing fault
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd_drive <= f[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rxd_drive <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- serial_port_control_tb.sv ----
// self-checking bench of the serial port control block in mode 2
// assumes the remote model at 32 clocks a bit; read data taken when pready is high
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defines.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module serial_port_control_tb;
  logic ref_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, txd_out, sck, sck_oe, rxd_o, rxd_oe, irq, rxd_line, got_stb;
  logic [10:0] got_frame, e11;
  logic [7:0] e8, d;
  logic [7:0] rd_q[$];
  logic [10:0] tx_q[$];
  int failures = 0;
  int checks_done = 0;
  // mode 0 data drive wins over the remote line
  wire rxd_wire = rxd_oe ? rxd_o : rxd_line;
  serial_port_control u_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rxd_pin(rxd_wire), .txd_out(txd_out), .shift_clk_out(sck),
    .shift_clk_oe(sck_oe), .rxd_out(rxd_o), .rxd_oe(rxd_oe), .irq(irq));
  serial_remote #(.BIT_CLKS(32)) u_remote (.ref_clk(ref_clk), .txd_in(txd_out),
    .rxd_drive(rxd_line), .got_stb(got_stb), .got_frame(got_frame));
  initial forever #50 ref_clk = ~ref_clk;
  // ****************************************
  // bus tasks and result monitor
  // ****************************************
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      if (++n > 50) begin failures++; close_out(); end
      @(posedge ref_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // bounded wait for an irq level, sampled away from the edge
  task automatic wait_irq(input logic want, input int lim);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (irq !== want && n < lim) begin @(negedge ref_clk); n++; end
    `CHK("irq", want, irq)
    if (irq !== want) close_out();
    @(posedge ref_clk);
  endtask
  // read data is taken at the edge where the access phase sees pready high
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e8 = rd_q.pop_front();
      `CHK("prdata", e8, prdata[7:0])
    end
    if (got_stb) begin
      e11 = tx_q.pop_front();
      `CHK("frame", e11, got_frame)
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h967559F3));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rd(`OFS_SERIAL_CONTROL, 8'h00);
    rd(12'h01C, 8'h00);
    apb(1'b1, `OFS_IRQ_MASK, 32'h7);
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h88);
    d = $urandom;
    tx_q.push_back({2'b11, d, 1'b0});
    apb(1'b1, `OFS_DATA, {24'h0, d});
    wait_irq(1'b1, 600);
    @(negedge ref_clk);
    `CHK("txd", 1'b1, txd_out)
    repeat (60) @(posedge ref_clk);
    rd(`OFS_SERIAL_CONTROL, 8'h8A);
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h98);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h2);
    rd(`OFS_IRQ_STATUS, 8'h00);
    apb(1'b1, `OFS_POWER_CONTROL, 32'h40);
    rd(`OFS_SERIAL_CONTROL, 8'h18);
    d = $urandom;
    u_remote.send({1'b0, d}, 1'b0);
    wait_irq(1'b1, 8);
    rd(`OFS_SERIAL_CONTROL, 8'h99);
    rd(`OFS_DATA, d);
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h98);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    d = $urandom;
    u_remote.send({1'b1, d}, 1'b1);
    wait_irq(1'b1, 8);
    rd(`OFS_SERIAL_CONTROL, 8'h9D);
    rd(`OFS_DATA, d);
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h18);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    rd(`OFS_SERIAL_CONTROL, 8'h18);
    apb(1'b1, `OFS_SERIAL_CONTROL, 32'h08);
    u_remote.send({1'b1, d}, 1'b1);
    repeat (40) @(posedge ref_clk);
    rd(`OFS_SERIAL_CONTROL, 8'h08);
    rd(`OFS_IRQ_STATUS, 8'h00);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    wait_irq(1'b0, 2);
    close_out();
  end
endmodule
`default_nettype wire
